// ### inc/uart_adv_pkg.sv
// Package with register map, field positions, reset values and timing for the control block.
package uart_adv_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_CTRL_TWO = 8'h00;
   localparam logic [7:0] OFF_CTRL_ONE = 8'h04;
   localparam logic [7:0] OFF_TURN = 8'h08;
   localparam logic [7:0] OFF_INT_STAT = 8'h0c;
   localparam logic [7:0] OFF_LINE_STAT = 8'h10;
   localparam logic [7:0] OFF_MODEM_STAT = 8'h14;
   // Field positions in advanced_control_two.
   localparam int B2_POLARITY = 5;
   localparam int B2_DIR_EN = 4;
   localparam int B2_PIN_SEL = 3;
   localparam int B2_TX_OFF = 2;
   localparam int B2_RX_OFF = 1;
   localparam int B2_MULTIDROP = 0;
   // Field positions in advanced_control_one.
   localparam int B1_WAKE_SENS = 4;
   localparam int B1_FLOW_SWAP = 2;
   localparam int B1_SW_RESET = 1;
   localparam int B1_TX_IRQ_MODE = 0;
   // Writable bit masks; reserved bits read as zero.
   localparam logic [7:0] MASK_CTRL_TWO = 8'h3f;
   localparam logic [7:0] MASK_CTRL_ONE = 8'h17;
   // Reset values.
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_INT_STAT = 8'h01;
   localparam logic [7:0] RST_LINE_STAT = 8'h60;
   localparam logic [3:0] RST_MODEM_DELTA = 4'h0;
   // Software reset length in crystal clocks.
   localparam logic [2:0] SW_RESET_CYCLES = 3'h4;
endpackage

// ### hdl/turnaround_timer.sv
// Turn-around delay counter that holds the line driver after the last bit has left.
`timescale 1ns/1ps
module turnaround_timer (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic start,
   input wire logic bitTick,
   input wire logic [7:0] delay,
   output logic holding
);
   // State of the counter.
   typedef struct packed {
      logic [7:0] count_r;
      logic run_r;
   } tt_state_type;

   tt_state_type st_r;
   tt_state_type st_nxt;

   // Load on start, count bit times down, release at zero.
   always_comb begin
      st_nxt = st_r;
      if (clear) begin
         st_nxt = '0;
      end else if (start) begin
         st_nxt.count_r = delay;
         st_nxt.run_r = (delay != 8'h00);
      end else if (st_r.run_r && bitTick) begin
         st_nxt.count_r = st_r.count_r - 8'h01;
         st_nxt.run_r = (st_r.count_r != 8'h01);
      end
   end

   // Register the state.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign holding = st_r.run_r;

   // Holding may only end on a bit tick or a clear.
   a_hold_ends_tick: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R20]
      $fell(holding) |-> $past(bitTick) || $past(clear))
      else $error("Turn-around hold ended without a bit tick.");
endmodule // turnaround_timer

// ### hdl/sleep_wake.sv
// Sleep entry and wake detection on the serial input.
`timescale 1ns/1ps
module sleep_wake (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic sleepReq,
   input wire logic edgeMode,
   input wire logic rxIn,
   output logic asleep
);
   // One-hot sleep states.
   typedef enum logic [1:0] {AWAKE = 2'b01, ASLEEP = 2'b10} sleep_st_type;
   typedef struct packed {
      sleep_st_type mode_r;
      logic rxPrev_r;
   } sw_state_type;

   sw_state_type st_r;
   sw_state_type st_nxt;

   // Enter when allowed by the input level, leave on low level or any toggle.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rxPrev_r = rxIn;
      if (clear) begin
         st_nxt.mode_r = AWAKE;
      end else begin
         unique case (st_r.mode_r)
            AWAKE: begin
               if (sleepReq && (edgeMode || rxIn)) begin // [R07] [R08]
                  st_nxt.mode_r = ASLEEP;
               end
            end
            ASLEEP: begin
               if (!edgeMode && !rxIn) begin // [R07]
                  st_nxt.mode_r = AWAKE;
               end else if (edgeMode && (rxIn != st_r.rxPrev_r)) begin // [R08]
                  st_nxt.mode_r = AWAKE;
               end
            end
            default: st_nxt.mode_r = AWAKE;
         endcase
      end
   end

   // Register the state.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{mode_r: AWAKE, rxPrev_r: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign asleep = (st_r.mode_r == ASLEEP);

   // Level mode never falls asleep with the input low.
   a_level_no_sleep: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R07]
      $rose(asleep) && !$past(edgeMode) |-> $past(rxIn))
      else $error("Entered sleep while the serial input was low.");
   // Edge mode wakes one cycle after a toggle.
   a_edge_wake: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R08]
      asleep && edgeMode && !clear && (rxIn != st_r.rxPrev_r) |=> !asleep)
      else $error("Did not wake on a toggle of the serial input.");
endmodule // sleep_wake

// ### hdl/uart_adv_ctrl.sv
// Advanced feature control, direction control and reset logic of one UART, with APB access.
//
// Contract
// R01: Polarity bit sets direction pin levels.
// R02: Transmitter drives direction pin only when enabled.
// R03: Pin select chooses request or terminal-ready.
// R04: Transmit-off bit stops the transmitter.
// R05: Receive-off bit stops the receiver independently.
// R06: Multidrop bit selects nine-bit mode.
// R07: Level wake: no sleep when input low.
// R08: Edge wake: sleep anyway, wake on toggle.
// R09: Swap bit moves flow control to alternates.
// R10: Software reset bit resets, then self-clears.
// R11: Software reset completes within four clocks.
// R12: Mode zero: interrupt on below-trigger or empty.
// R13: Mode one: empty also waits shifter done.
// R14: Pin and software reset give same values.
// R15: Reset clears control registers to zero.
// R16: Reset gives interrupt status value one.
// R17: Reset sets line status bits six, five.
// R18: Reset modem status follows pins, deltas zero.
// R19: Reset drives outputs high, interrupt low.
// R20: Turn-around delay counts before receive direction.
// R21: Reserved bits read zero, writes ignored.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module uart_adv_ctrl (
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Status from the transmitter, FIFOs and baud logic.
   input wire logic txSerial,
   input wire logic txShiftBusy,
   input wire logic txBelowTrigger,
   input wire logic txFifoEmpty,
   input wire logic bitTick,
   input wire logic txIrqEnable,
   input wire logic sleepReq,
   input wire logic rtsAssert,
   input wire logic dtrAssert,
   input wire logic flowReady,
   // Serial and modem pins.
   input wire logic rxIn,
   input wire logic cts_b,
   input wire logic dsr_b,
   input wire logic dcd_b,
   input wire logic ri_b,
   output logic txOut,
   output logic rts_b,
   output logic dtr_b,
   output logic intOut,
   output logic irqOut,
   output logic irqOe_b,
   // Controls to the rest of the UART.
   output logic txEnable,
   output logic rxEnable,
   output logic multidropMode,
   output logic flowClear,
   output logic uartReset,
   output logic asleep
);
   // Whole register state of the block.
   typedef struct packed {
      logic [7:0] ctrlTwo_r;
      logic [7:0] ctrlOne_r;
      logic [7:0] turn_r;
      logic [7:0] intStat_r;
      logic [7:0] lineStat_r;
      logic [3:0] modemDelta_r;
      logic [3:0] modemPrev_r;
      logic [2:0] rstCount_r;
      logic [31:0] rdata_r;
      logic err_r;
      logic txOut_r;
      logic rts_r;
      logic dtr_r;
      logic int_r;
      logic txBusyPrev_r;
      logic seeded_r;
   } ctrl_state_type;

   ctrl_state_type st_r;
   ctrl_state_type st_nxt;
   logic setupPhase; // First cycle of an APB transfer.
   logic accessWr; // Write that completes at this edge.
   logic accessRd; // Read that completes at this edge.
   logic swResetActive; // Software reset in progress.
   logic dirHold; // Turn-around delay still running.
   logic dirTransmit; // Line driver should face the line.
   logic dirLevel; // Level for the direction pin.
   logic dirActive; // Transmitter owns a direction pin.
   logic txEmptyIrq; // Transmit-empty interrupt condition.
   logic txDone; // Shift register just went idle.
   logic [3:0] modemPins; // Modem inputs as active-high levels.

   assign modemPins = {~dcd_b, ~ri_b, ~dsr_b, ~cts_b};
   assign setupPhase = psel && !penable;
   assign accessWr = psel && penable && pwrite;
   assign accessRd = psel && penable && !pwrite;
   assign swResetActive = (st_r.rstCount_r != 3'h0);
   assign txDone = st_r.txBusyPrev_r && !txShiftBusy;

   // Turn-around delay after the last bit in nine-bit mode.
   turnaround_timer u_turn (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(swResetActive),
      .start(txDone && multidropMode),
      .bitTick(bitTick),
      .delay(st_r.turn_r),
      .holding(dirHold)
   );

   // Sleep entry and wake.
   sleep_wake u_sleep (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clear(swResetActive),
      .sleepReq(sleepReq),
      .edgeMode(st_r.ctrlOne_r[uart_adv_pkg::B1_WAKE_SENS]),
      .rxIn(rxIn),
      .asleep(asleep)
   );

   // Decoded control bits.
   assign multidropMode = st_r.ctrlTwo_r[uart_adv_pkg::B2_MULTIDROP]; // [R06]
   assign txEnable = !st_r.ctrlTwo_r[uart_adv_pkg::B2_TX_OFF] && !swResetActive; // [R04]
   assign rxEnable = !st_r.ctrlTwo_r[uart_adv_pkg::B2_RX_OFF] && !swResetActive; // [R05]
   assign uartReset = swResetActive;
   assign dirActive = multidropMode && st_r.ctrlTwo_r[uart_adv_pkg::B2_DIR_EN]; // [R02]
   // The cycle in which the shifter empties is bridged until the timer has loaded.
   assign dirTransmit = txShiftBusy || dirHold || (txDone && (|st_r.turn_r)); // [R20]
   // Low while transmitting, high while receiving, swapped by polarity.
   assign dirLevel = !dirTransmit ^ st_r.ctrlTwo_r[uart_adv_pkg::B2_POLARITY]; // [R01]

   // Clear-to-send source for the transmitter's flow control.
   always_comb begin
      if (st_r.ctrlOne_r[uart_adv_pkg::B1_FLOW_SWAP]) begin
         flowClear = !dsr_b; // [R09]
      end else begin
         flowClear = !cts_b;
      end
   end

   // Transmit-empty condition in the two modes.
   always_comb begin
      if (st_r.ctrlOne_r[uart_adv_pkg::B1_TX_IRQ_MODE]) begin
         txEmptyIrq = txBelowTrigger || (txFifoEmpty && !txShiftBusy); // [R13]
      end else begin
         txEmptyIrq = txBelowTrigger || txFifoEmpty; // [R12]
      end
   end

   // Next-state logic for registers, pins and the bus.
   always_comb begin
      logic rtsOn;
      logic dtrOn;
      rtsOn = 1'b0;
      dtrOn = 1'b0;
      st_nxt = st_r;
      st_nxt.txBusyPrev_r = txShiftBusy;
      st_nxt.modemPrev_r = modemPins;
      // Modem deltas are set on change; a set wins over the read that clears.
      if (accessRd && paddr == uart_adv_pkg::OFF_MODEM_STAT) begin
         st_nxt.modemDelta_r = 4'h0;
      end
      // No delta in the first cycle after reset, when the previous levels are not yet known.
      st_nxt.seeded_r = 1'b1;
      st_nxt.modemDelta_r = st_nxt.modemDelta_r
         | ((modemPins ^ st_r.modemPrev_r) & {4{st_r.seeded_r}}); // [R18]
      // Interrupt status: bit 0 high when nothing pends.
      st_nxt.intStat_r = {6'h00, txEmptyIrq && txIrqEnable, !(txEmptyIrq && txIrqEnable)};
      // Line status: transmitter empty flags.
      st_nxt.lineStat_r = {1'b0, txFifoEmpty && !txShiftBusy, txFifoEmpty, 5'h00};
      // Flow-control and modem request levels on the pins.
      if (st_r.ctrlOne_r[uart_adv_pkg::B1_FLOW_SWAP]) begin
         rtsOn = rtsAssert; // [R09]
         dtrOn = dtrAssert && flowReady;
      end else begin
         rtsOn = rtsAssert && flowReady;
         dtrOn = dtrAssert;
      end
      st_nxt.rts_r = !rtsOn;
      st_nxt.dtr_r = !dtrOn;
      // Direction pin override in nine-bit mode.
      if (dirActive) begin
         if (st_r.ctrlTwo_r[uart_adv_pkg::B2_PIN_SEL]) begin
            st_nxt.dtr_r = dirLevel; // [R03]
         end else begin
            st_nxt.rts_r = dirLevel; // [R03]
         end
      end
      // Disabled transmitter holds the line idle.
      st_nxt.txOut_r = txEnable ? txSerial : 1'b1; // [R04]
      st_nxt.int_r = txEmptyIrq && txIrqEnable;
      // Read data is captured in the setup cycle.
      st_nxt.err_r = 1'b0;
      if (setupPhase) begin
         st_nxt.rdata_r = 32'h0000_0000;
         unique case (paddr)
            uart_adv_pkg::OFF_CTRL_TWO: st_nxt.rdata_r[7:0] = st_r.ctrlTwo_r;
            uart_adv_pkg::OFF_CTRL_ONE: st_nxt.rdata_r[7:0] = st_r.ctrlOne_r;
            uart_adv_pkg::OFF_TURN: st_nxt.rdata_r[7:0] = st_r.turn_r;
            uart_adv_pkg::OFF_INT_STAT: st_nxt.rdata_r[7:0] = st_r.intStat_r;
            uart_adv_pkg::OFF_LINE_STAT: st_nxt.rdata_r[7:0] = st_r.lineStat_r;
            uart_adv_pkg::OFF_MODEM_STAT: begin
               st_nxt.rdata_r[7:0] = {modemPins, st_r.modemDelta_r};
            end
            default: st_nxt.err_r = 1'b1;
         endcase
      end
      // Writes; reserved bits are masked off.
      if (accessWr) begin
         unique case (paddr)
            uart_adv_pkg::OFF_CTRL_TWO: begin
               st_nxt.ctrlTwo_r = pwdata[7:0] & uart_adv_pkg::MASK_CTRL_TWO; // [R21]
            end
            uart_adv_pkg::OFF_CTRL_ONE: begin
               st_nxt.ctrlOne_r = pwdata[7:0] & uart_adv_pkg::MASK_CTRL_ONE; // [R21]
            end
            uart_adv_pkg::OFF_TURN: st_nxt.turn_r = pwdata[7:0];
            default: st_nxt.turn_r = st_r.turn_r;
         endcase
      end
      // Software reset: start on a write of one, run four clocks.
      if (swResetActive) begin
         st_nxt.rstCount_r = st_r.rstCount_r - 3'h1; // [R11]
      end else if (st_nxt.ctrlOne_r[uart_adv_pkg::B1_SW_RESET]) begin
         st_nxt.rstCount_r = uart_adv_pkg::SW_RESET_CYCLES; // [R10]
      end
      // During software reset load the same values as the reset pin.
      if (swResetActive) begin
         st_nxt.ctrlTwo_r = uart_adv_pkg::RST_CTRL; // [R14] [R15]
         st_nxt.ctrlOne_r = uart_adv_pkg::RST_CTRL; // [R10] [R15]
         st_nxt.turn_r = uart_adv_pkg::RST_CTRL; // [R15]
         st_nxt.intStat_r = uart_adv_pkg::RST_INT_STAT; // [R16]
         st_nxt.lineStat_r = uart_adv_pkg::RST_LINE_STAT; // [R17]
         st_nxt.modemDelta_r = uart_adv_pkg::RST_MODEM_DELTA; // [R18]
         st_nxt.txOut_r = 1'b1; // [R19]
         st_nxt.rts_r = 1'b1; // [R19]
         st_nxt.dtr_r = 1'b1; // [R19]
         st_nxt.int_r = 1'b0; // [R19]
      end
   end

   // Register the whole state; pin reset loads the same constants.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0; // [R14] [R15]
         st_r.intStat_r <= uart_adv_pkg::RST_INT_STAT; // [R16]
         st_r.lineStat_r <= uart_adv_pkg::RST_LINE_STAT; // [R17]
         st_r.modemPrev_r <= 4'h0; // [R18]
         st_r.txOut_r <= 1'b1; // [R19]
         st_r.rts_r <= 1'b1; // [R19]
         st_r.dtr_r <= 1'b1; // [R19]
         st_r.txBusyPrev_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs from flip-flops except the tied pready and irqOut and the bus-gated pslverr; the open-drain request pulls low while the interrupt stands.
   assign prdata = st_r.rdata_r;
   assign pready = 1'b1;
   assign pslverr = st_r.err_r && psel && penable;
   assign txOut = st_r.txOut_r;
   assign rts_b = st_r.rts_r;
   assign dtr_b = st_r.dtr_r;
   assign intOut = st_r.int_r;
   assign irqOut = 1'b0;
   assign irqOe_b = !st_r.int_r; // [R19]

   // Steps of a software reset.
   sequence s_sw_start;
      accessWr && paddr == uart_adv_pkg::OFF_CTRL_ONE && pwdata[1] && !swResetActive;
   endsequence
   sequence s_sw_run;
      swResetActive [*4];
   endsequence

   a_swreset_len: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R11]
      s_sw_start |=> s_sw_run ##1 !swResetActive)
      else $error("Software reset did not last exactly four clocks.");
   a_swreset_clear: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R10]
      s_sw_start |-> ##5 st_r.ctrlOne_r == 8'h00)
      else $error("Software reset bit did not clear itself.");
   a_reset_values: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
      $fell(swResetActive) |-> st_r.intStat_r == 8'h01 && st_r.lineStat_r == 8'h60
      && st_r.ctrlTwo_r == 8'h00 && st_r.turn_r == 8'h00)
      else $error("Software reset left wrong register values.");
   a_reset_pins: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R19]
      $fell(swResetActive) |-> txOut && rts_b && dtr_b && !intOut && irqOe_b)
      else $error("Outputs not at reset levels after software reset.");
   a_dir_level: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R01]
      dirActive && !swResetActive && !st_r.ctrlTwo_r[3] && $stable(st_r.ctrlTwo_r)
      |=> rts_b == (!$past(dirTransmit) ^ $past(st_r.ctrlTwo_r[5])))
      else $error("Direction pin level wrong in nine-bit mode.");
   a_tx_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R04]
      st_r.ctrlTwo_r[2] |=> txOut)
      else $error("Transmitter drove the line while disabled.");
   a_rx_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R05]
      st_r.ctrlTwo_r[1] |-> !rxEnable)
      else $error("Receiver enabled while receive-off bit is set.");
   a_irq_mode1: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
      st_r.ctrlOne_r[0] && !txBelowTrigger && txShiftBusy |=> !intOut)
      else $error("Transmit-empty raised before the shifter emptied.");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R21]
      (st_r.ctrlTwo_r & ~uart_adv_pkg::MASK_CTRL_TWO) == 8'h00)
      else $error("Reserved control bits became set.");
endmodule // uart_adv_ctrl

// ### dv/line_partner.sv
// Model of the line transceiver and modem lines at the far side of the control block.
`timescale 1ns/1ps
module line_partner #(
   parameter bit SLOW = 1'b0 // When set, line changes reach the block one clock late.
) (
   input wire logic ref_clk,
   input wire logic dirPin,
   input wire logic [4:0] want,
   output logic rxIn,
   output logic cts_b,
   output logic dsr_b,
   output logic dcd_b,
   output logic ri_b,
   output logic lineBusy
);
   logic [4:0] late_r = 5'h1f; // Delayed copy of the requested levels.

   // The slow transceiver passes pin levels on one clock later.
   always_ff @(posedge ref_clk) begin
      late_r <= want;
   end

   // Requested levels order is serial input, then clear, set-ready, carrier and ring.
   assign {rxIn, cts_b, dsr_b, dcd_b, ri_b} = SLOW ? late_r : want;
   // The driver is on while the direction pin is low.
   assign lineBusy = ~dirPin;
endmodule // line_partner

// ### dv/uart_adv_ctrl_bench.sv
// Self-checking testbench for the advanced control and reset block of the UART.
`timescale 1ns/1ps
module uart_adv_ctrl_bench;
   logic ref_clk = 1'b0; // Clock at 10 MHz.
   logic rst_b = 1'b0; // Reset, active low.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic txOut, rts_b, dtr_b, intOut, irqOut, irqOe_b, lineBusy;
   logic txEnable, rxEnable, multidropMode, flowClear, uartReset, asleep;
   logic txSerial = 1'b1, txShiftBusy = 1'b0, txBelowTrigger = 1'b0, txFifoEmpty = 1'b1;
   logic bitTick = 1'b0, txIrqEnable = 1'b0, sleepReq = 1'b0, rtsAssert = 1'b0;
   logic dtrAssert = 1'b0, flowReady = 1'b1;
   logic rxIn, cts_b, dsr_b, dcd_b, ri_b;
   logic [4:0] want = 5'h15; // Serial input high, clear-to-send and carrier asserted.
   int miscompares = 0, comparisons = 0;

   // Free-running clock with a 100 ns period.
   always #50 ref_clk = ~ref_clk;

   // Short names for the control register offsets.
   localparam logic [7:0] CTL2 = uart_adv_pkg::OFF_CTRL_TWO;
   localparam logic [7:0] CTL1 = uart_adv_pkg::OFF_CTRL_ONE;
   localparam logic [7:0] TURN = uart_adv_pkg::OFF_TURN;

   uart_adv_ctrl u_uart_adv_ctrl (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .txSerial, .txShiftBusy, .txBelowTrigger, .txFifoEmpty,
      .bitTick, .txIrqEnable, .sleepReq, .rtsAssert, .dtrAssert, .flowReady, .rxIn, .cts_b,
      .dsr_b, .dcd_b, .ri_b, .txOut, .rts_b, .dtr_b, .intOut, .irqOut, .irqOe_b, .txEnable,
      .rxEnable, .multidropMode, .flowClear, .uartReset, .asleep);

   line_partner #(.SLOW(1'b1)) u_line_partner (.ref_clk, .dirPin(rts_b), .want, .rxIn, .cts_b,
      .dsr_b, .dcd_b, .ri_b, .lineBusy);

   // Prints the verdict and stops the run.
   task automatic end_sim;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Waits n edges, then settles past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Compares one value and counts the outcome.
   task automatic chkVal(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s is %h, want %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; response values are those standing at the completing edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      logic rdy;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      rdy = 1'b0;
      for (int i = 0; i < 16 && rdy !== 1'b1; i++) begin
         #1;
         rdy = pready;
         rd = prdata;
         err = pslverr;
         @(posedge ref_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      chkVal(rdy, 1'b1, "ready");
   endtask

   // Register write that ignores the response.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   // Register read compared with its expected word and error flag.
   task automatic chkReg(input logic [7:0] a, input logic [7:0] exp, input logic err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      comparisons++;
      if (r !== {24'h000000, exp} || e !== err) begin
         miscompares++;
         $display("unexpected at %0t: read %h gave %h/%b", $time, a, r, e);
      end
   endtask

   // Values of registers and pins straight after reset.
   task automatic t_reset;
      chkVal({txOut, rts_b, dtr_b, intOut, irqOe_b, irqOut}, 8'h3a, "reset pins");
      chkReg(CTL2, 8'h00, 1'b0);
      chkReg(CTL1, 8'h00, 1'b0);
      chkReg(TURN, 8'h00, 1'b0);
      chkReg(uart_adv_pkg::OFF_INT_STAT, 8'h01, 1'b0);
      chkReg(uart_adv_pkg::OFF_LINE_STAT, 8'h60, 1'b0);
      chkReg(uart_adv_pkg::OFF_MODEM_STAT, 8'h90, 1'b0);
   endtask

   // Reserved bits, a read-only place and an unmapped address.
   task automatic t_reserved;
      wr(CTL2, 8'hff);
      chkReg(CTL2, 8'h3f, 1'b0);
      wr(CTL1, 8'hfd);
      chkReg(CTL1, 8'h15, 1'b0);
      wr(uart_adv_pkg::OFF_LINE_STAT, 8'h00);
      chkReg(uart_adv_pkg::OFF_LINE_STAT, 8'h60, 1'b0);
      chkReg(8'h18, 8'h00, 1'b1);
      wr(CTL2, 8'h00);
      wr(CTL1, 8'h00);
   endtask

   // Transmitter and receiver off bits and the multidrop mode bit.
   task automatic t_enables;
      wr(CTL2, 8'h04);
      txSerial <= 1'b0;
      tick(2);
      chkVal({txEnable, rxEnable, txOut}, 8'h03, "tx off");
      wr(CTL2, 8'h02);
      tick(2);
      chkVal({txEnable, rxEnable, txOut}, 8'h04, "rx off");
      wr(CTL2, 8'h01);
      txSerial <= 1'b1;
      tick(2);
      chkVal({multidropMode, rxEnable}, 8'h03, "multidrop on");
      wr(CTL2, 8'h00);
      tick(2);
      chkVal(multidropMode, 1'b0, "multidrop off");
   endtask

   // Starts or ends a transmission, then waits n cycles.
   task automatic shift(input logic busy, input int n);
      @(posedge ref_clk);
      txShiftBusy <= busy;
      tick(n);
   endtask

   // One bit-time pulse followed by settling cycles.
   task automatic pulseTick;
      @(posedge ref_clk);
      bitTick <= 1'b1;
      @(posedge ref_clk);
      bitTick <= 1'b0;
      tick(3);
   endtask

   // Direction pin enable, polarity, pin choice and the turn-around delay.
   task automatic t_direction;
      wr(TURN, 8'h02);
      wr(CTL2, 8'h01);
      shift(1'b1, 3);
      chkVal(rts_b, 1'b1, "pin left alone");
      shift(1'b0, 1);
      wr(CTL2, 8'h11);
      shift(1'b1, 3);
      chkVal({rts_b, dtr_b, lineBusy}, 8'h03, "driving");
      shift(1'b0, 1);
      chkVal(rts_b, 1'b0, "turn-around held");
      pulseTick;
      chkVal(rts_b, 1'b0, "turn-around one tick");
      pulseTick;
      chkVal(rts_b, 1'b1, "turn-around done");
      wr(TURN, 8'h00);
      wr(CTL2, 8'h31);
      shift(1'b1, 3);
      chkVal(rts_b, 1'b1, "inverted sending");
      shift(1'b0, 4);
      chkVal(rts_b, 1'b0, "inverted receiving");
      wr(CTL2, 8'h19);
      shift(1'b1, 3);
      chkVal({rts_b, dtr_b}, 8'h02, "terminal pin sending");
      shift(1'b0, 4);
      chkVal({rts_b, dtr_b}, 8'h03, "terminal pin receiving");
      wr(CTL2, 8'h00);
   endtask

   // Flow control on the ordinary pins, then on the alternate pins.
   task automatic t_flow;
      @(posedge ref_clk);
      rtsAssert <= 1'b1;
      dtrAssert <= 1'b1;
      flowReady <= 1'b0;
      tick(2);
      chkVal({flowClear, rts_b, dtr_b}, 8'h06, "flow ordinary");
      wr(CTL1, 8'h04);
      tick(2);
      chkVal({flowClear, rts_b, dtr_b}, 8'h01, "flow swapped");
      rtsAssert <= 1'b0;
      dtrAssert <= 1'b0;
      flowReady <= 1'b1;
      wr(CTL1, 8'h00);
   endtask

   // Level and edge wake sensitivity of the serial input.
   task automatic t_sleep;
      logic woke;
      @(posedge ref_clk);
      want <= 5'h05;
      @(posedge ref_clk);
      sleepReq <= 1'b1;
      tick(4);
      chkVal(asleep, 1'b0, "sleep with input low");
      want <= 5'h15;
      tick(4);
      chkVal(asleep, 1'b1, "sleep with input high");
      want <= 5'h05;
      tick(4);
      chkVal(asleep, 1'b0, "level wake");
      wr(CTL1, 8'h10);
      tick(4);
      chkVal(asleep, 1'b1, "edge sleep with input low");
      want <= 5'h15;
      woke = 1'b0;
      for (int i = 0; i < 5; i++) begin
         tick(1);
         woke = woke | (asleep === 1'b0);
      end
      chkVal(woke, 1'b1, "edge wake");
      sleepReq <= 1'b0;
      wr(CTL1, 8'h00);
   endtask

   // Transmit-empty interrupt in both modes.
   task automatic t_irq;
      @(posedge ref_clk);
      txIrqEnable <= 1'b1;
      txFifoEmpty <= 1'b1;
      shift(1'b1, 3);
      chkVal({intOut, irqOe_b}, 8'h02, "empty irq mode zero");
      wr(CTL1, 8'h01);
      tick(2);
      chkVal(intOut, 1'b0, "empty waits for shifter");
      shift(1'b0, 3);
      chkVal(intOut, 1'b1, "shifter done");
      txBelowTrigger <= 1'b1;
      shift(1'b1, 3);
      chkVal(intOut, 1'b1, "below trigger mode one");
      txBelowTrigger <= 1'b0;
      txIrqEnable <= 1'b0;
      shift(1'b0, 3);
      chkVal({intOut, irqOe_b}, 8'h01, "irq released");
   endtask

   // Software reset length, self-clearing and equal outcome to the pin reset.
   task automatic t_swreset;
      int n;
      wr(CTL2, 8'h3f);
      wr(TURN, 8'h5a);
      wr(CTL1, 8'h02);
      n = 0;
      for (int i = 0; i < 10; i++) begin
         #1;
         n += int'(uartReset === 1'b1);
         @(posedge ref_clk);
      end
      chkVal(n[7:0], 8'h04, "reset length");
      chkReg(CTL1, 8'h00, 1'b0);
      chkReg(CTL2, 8'h00, 1'b0);
      chkReg(TURN, 8'h00, 1'b0);
      wr(CTL2, 8'h3f);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      tick(2);
      rst_b <= 1'b1;
      tick(1);
      t_reset;
   endtask

   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      tick(1);
      t_reset;
      t_reserved;
      t_enables;
      t_direction;
      t_flow;
      t_sleep;
      t_irq;
      t_swreset;
      end_sim;
   end

   // Watchdog: a hang counts as a mismatch.
   initial begin
      #2000000;
      miscompares++;
      end_sim;
   end
endmodule // uart_adv_ctrl_bench
